// >>> rtl/fabpc_pkg.sv
package fabpc_pkg;
  localparam int CLK_NS = 20;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int RD_RECOVERY_NS = 300;
  localparam int WR_RECOVERY_NS = 215;
  localparam int RD_RECOVERY_CYC = (RD_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_RECOVERY_CYC = (WR_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = 2;
  localparam int STROBE_CYC = 3;
  localparam int HOLD_CYC = 1;
  localparam int READ_CYC = 5;
  localparam int CNT_W = 5;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_IDENT = 2'h2;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  typedef enum logic [2:0] {FABPC_DOWN, FABPC_WAKE, FABPC_IDLE, FABPC_SETUP,
    FABPC_ACTIVE, FABPC_HOLD, FABPC_DATA} fabpc_state_t;
endpackage

// >>> rtl/fabpc_host.sv
`timescale 1ns/1ns
module fabpc_host
  import fabpc_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire logic [1:0] req_op_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  input wire logic req_byte_in,
  input wire logic req_program_in,
  input wire logic powerdown_req_in,
  input wire logic [DATA_W-1:0] mem_dq_in,
  output logic req_ready_out,
  output logic resp_valid_out,
  output logic [DATA_W-1:0] resp_rdata_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [DATA_W-1:0] mem_dq_out,
  output logic [DATA_W-1:0] mem_dq_oe_out,
  output logic chip_select_n_out,
  output logic output_gate_n_out,
  output logic write_strobe_n_out,
  output logic width_word_out,
  output logic powerdown_reset_n_out,
  output logic signature_hv_pin_out
);

  fabpc_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [1:0] op, next_op;
  logic byte_mode, next_byte_mode;
  logic prog_pend, next_prog_pend;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic [CNT_W-1:0] wr_gap, next_wr_gap;
  logic resp, next_resp;

  function automatic logic [DATA_W-1:0] fabpc_lane_mask(input logic bytew);
    // byte mode: lane fifteen is an address bit, lanes 8..14 float
    fabpc_lane_mask = bytew ? {1'b1, 7'h00, 8'hFF} : 16'hFFFF;
  endfunction

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_op = op;
    next_byte_mode = byte_mode;
    next_prog_pend = prog_pend;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_resp = 1'b0;
    next_wr_gap = (wr_gap != '0) ? wr_gap - 1'b1 : wr_gap;
    case (state)
      FABPC_DOWN:
      begin
        if (!powerdown_req_in)
        begin
          next_state = FABPC_WAKE;
          next_cnt = CNT_W'(RD_RECOVERY_CYC);
          next_wr_gap = CNT_W'(WR_RECOVERY_CYC);
        end
      end
      FABPC_WAKE:
      begin
        // recovery wait, read and write delays both run out
        if (cnt == '0 && wr_gap == '0)
          next_state = FABPC_IDLE;
      end
      FABPC_IDLE:
      begin
        if (powerdown_req_in)
        begin
          next_state = FABPC_DOWN;
          next_prog_pend = 1'b0;
        end
        else if (req_valid_in)
        begin
          next_op = req_op_in;
          next_byte_mode = req_byte_in;
          next_addr = req_addr_in;
          next_wdata = (req_op_in == OP_WRITE && req_program_in) ?
            {8'h00, CMD_PROGRAM} : req_wdata_in;
          next_prog_pend = (req_op_in == OP_WRITE) && req_program_in;
          next_state = FABPC_SETUP;
          next_cnt = CNT_W'(SETUP_CYC);
        end
      end
      FABPC_SETUP:
      begin
        if (cnt == '0)
        begin
          next_state = FABPC_ACTIVE;
          next_cnt = CNT_W'((op == OP_WRITE) ? STROBE_CYC : READ_CYC);
        end
      end
      FABPC_ACTIVE:
      begin
        if (cnt == '0)
        begin
          if (op != OP_WRITE)
            next_rdata = mem_dq_in & fabpc_lane_mask(byte_mode);
          next_state = FABPC_HOLD;
          next_cnt = CNT_W'(HOLD_CYC);
        end
      end
      FABPC_HOLD:
      begin
        if (cnt == '0)
        begin
          if (prog_pend)
          begin
            next_prog_pend = 1'b0;
            next_wdata = req_wdata_in;
            next_state = FABPC_SETUP;
            next_cnt = CNT_W'(SETUP_CYC);
          end
          else
          begin
            next_state = FABPC_DATA;
            next_resp = 1'b1;
          end
        end
      end
      FABPC_DATA:
        next_state = FABPC_IDLE;
      default:
        next_state = FABPC_DOWN;
    endcase
    if (powerdown_req_in && state != FABPC_DOWN && state != FABPC_IDLE)
    begin
      next_state = FABPC_DOWN;
      next_prog_pend = 1'b0;
      next_resp = 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state <= FABPC_DOWN;
      cnt <= '0;
      op <= OP_READ;
      byte_mode <= 1'b0;
      prog_pend <= 1'b0;
      addr <= '0;
      wdata <= '0;
      rdata <= '0;
      resp <= 1'b0;
      wr_gap <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      op <= next_op;
      byte_mode <= next_byte_mode;
      prog_pend <= next_prog_pend;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      resp <= next_resp;
      wr_gap <= next_wr_gap;
    end
  end

  ////////////////////////////////////////////////////////////////////
  logic next_cs_n, next_oe_n, next_we_n, next_pwd_n, next_hv, next_wordw;
  logic [DATA_W-1:0] next_dq_oe;
  logic bus_on;

  always_comb
  begin
    bus_on = (next_state == FABPC_SETUP) || (next_state == FABPC_ACTIVE) ||
      (next_state == FABPC_HOLD);
    next_cs_n = !bus_on;
    next_oe_n = !((next_op != OP_WRITE) && bus_on);
    next_we_n = !((next_op == OP_WRITE) && next_state == FABPC_ACTIVE);
    next_pwd_n = (next_state != FABPC_DOWN);
    next_hv = (next_op == OP_IDENT) && bus_on;
    next_wordw = !next_byte_mode;
    // writes drive lanes; byte reads drive lane fifteen only
    next_dq_oe = '0;
    if (bus_on && next_op == OP_WRITE)
      next_dq_oe = fabpc_lane_mask(next_byte_mode);
    else if (bus_on && next_byte_mode)
      next_dq_oe = 16'h8000;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      chip_select_n_out <= 1'b1;
      output_gate_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      powerdown_reset_n_out <= 1'b0;
      signature_hv_pin_out <= 1'b0;
      width_word_out <= 1'b1;
      mem_dq_oe_out <= '0;
      mem_addr_out <= '0;
      mem_dq_out <= '0;
      req_ready_out <= 1'b0;
      resp_valid_out <= 1'b0;
      resp_rdata_out <= '0;
    end
    else
    begin
      chip_select_n_out <= next_cs_n;
      output_gate_n_out <= next_oe_n;
      write_strobe_n_out <= next_we_n;
      powerdown_reset_n_out <= next_pwd_n;
      signature_hv_pin_out <= next_hv;
      width_word_out <= next_wordw;
      mem_dq_oe_out <= next_dq_oe;
      mem_addr_out <= next_addr;
      mem_dq_out <= next_byte_mode ? {next_addr[0], 7'h00, next_wdata[7:0]} : next_wdata;
      req_ready_out <= (next_state == FABPC_IDLE) && !powerdown_req_in;
      resp_valid_out <= next_resp;
      resp_rdata_out <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // cycles since the powerdown pin rose, saturating
  logic [CNT_W-1:0] wake_age, next_wake_age;

  always_comb
  begin
    next_wake_age = wake_age;
    if (!powerdown_reset_n_out)
      next_wake_age = '0;
    else if (wake_age != '1)
      next_wake_age = wake_age + 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      wake_age <= '0;
    else
      wake_age <= next_wake_age;
  end

  chk_wake_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(powerdown_reset_n_out) |-> chip_select_n_out [*8])
    else $error("access too soon after powerdown release");
  chk_wake_full: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !chip_select_n_out |-> wake_age >= CNT_W'(RD_RECOVERY_CYC))
    else $error("select before read recovery ended");
  chk_read_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !output_gate_n_out |-> chip_select_n_out == 1'b0 && write_strobe_n_out)
    else $error("gate active outside read");
  chk_dq_float: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!output_gate_n_out || chip_select_n_out) |->
    mem_dq_oe_out == ((chip_select_n_out || width_word_out) ? 16'h0000 : 16'h8000))
    else $error("host drives lanes during read or idle");
  chk_strobe_cs: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(write_strobe_n_out) |-> !chip_select_n_out && $stable(mem_addr_out))
    else $error("address moved at strobe rise");
  chk_pwd_abort: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    powerdown_req_in |-> ##1 (chip_select_n_out && !powerdown_reset_n_out))
    else $error("powerdown did not abort");
  chk_pwd_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !powerdown_reset_n_out |-> chip_select_n_out && write_strobe_n_out)
    else $error("bus active in powerdown");
  chk_byte_float: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !width_word_out |-> mem_dq_oe_out[14:8] == 7'h00)
    else $error("middle lanes driven in byte mode");
  chk_hv_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    signature_hv_pin_out |-> write_strobe_n_out && !chip_select_n_out)
    else $error("identifier level outside read");
  cov_read: cover property (@(posedge clk_in) $fell(output_gate_n_out));
  cov_write: cover property (@(posedge clk_in) $rose(write_strobe_n_out));
  cov_ident: cover property (@(posedge clk_in) $rose(signature_hv_pin_out));
  cov_wake: cover property (@(posedge clk_in) $rose(powerdown_reset_n_out));
endmodule

// >>> test/fabpc_flash_model.sv
`timescale 1ns/1ns
module fabpc_flash_model
  import fabpc_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'hB3A5,
  parameter logic [15:0] PART_CODE = 16'h5A3C,
  // boot block sits at the top of the word map
  parameter logic [ADDR_W-1:0] BOOT_BASE = 18'h3E000
)
(
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic cs_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic word_in,
  input wire logic pd_n_in,
  input wire logic sig_hv_in,
  input wire logic boot_unlock_in,
  input wire logic vpp_ok_in,
  output logic [DATA_W-1:0] dq_out,
  output logic [DATA_W-1:0] dq_oe_out
);
  logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];
  logic [DATA_W-1:0] rd, pw;
  logic [ADDR_W-1:0] pa;
  logic armed = 1'h0, busy = 1'h0, rd_ok = 1'h0, wr_ok = 1'h0;
  // erased array reads all ones
  initial
  begin
    for (int i = 0; i < (1 << ADDR_W); i++)
      mem[i] = 16'hFFFF;
  end
  always @(negedge pd_n_in)
  begin
    {armed, busy, rd_ok, wr_ok} = 4'h0;
  end
  always @(posedge pd_n_in)
  begin
    #215 wr_ok = 1'h1;
    #85 rd_ok = 1'h1;
  end
  always @(posedge we_n_in)
  begin
    if (!cs_n_in && pd_n_in && wr_ok)
    begin
      if (armed)
      begin
        pa = addr_in;
        pw = mem[addr_in];
        if (word_in)
          pw = dq_in;
        else if (dq_in[15])
          pw[15:8] = dq_in[7:0];
        else
          pw[7:0] = dq_in[7:0];
        // boot block locked or supply too low
        if (vpp_ok_in && (boot_unlock_in || addr_in < BOOT_BASE))
          busy = 1'h1;
      end
      armed = !armed && dq_in[7:0] == CMD_PROGRAM;
    end
  end
  // timed program, so a powerdown can cut it short
  always @(posedge busy)
  begin
    #400;
    if (busy)
      mem[pa] = pw;
    busy = 1'h0;
  end
  always @(addr_in, dq_in, cs_n_in, oe_n_in, word_in, pd_n_in, sig_hv_in, rd_ok, busy)
  begin
    rd = sig_hv_in ? (addr_in[0] ? PART_CODE : MAKER_CODE) : mem[addr_in];
    if (!word_in && !sig_hv_in && dq_in[15])
      rd = rd >> 8;
    dq_oe_out = '0;
    if (!cs_n_in && !oe_n_in && pd_n_in)
      dq_oe_out = word_in ? 16'hFFFF : 16'h00FF;
    // early reads see wrong data
    dq_out = rd_ok ? rd : ~rd;
  end
endmodule

// >>> test/test_flash_async_bus_pin_control.sv
`timescale 1ns/1ns
module test_flash_async_bus_pin_control;
  import fabpc_pkg::*;
  // identifier values are arbitrary
  localparam logic [15:0] MAKER = 16'hB3A5;
  localparam logic [15:0] PART = 16'h5A3C;
  logic clk_in = 1'h0, sys_rst_in = 1'h1, req_valid_in = 1'h0, req_byte_in = 1'h0;
  logic req_program_in = 1'h0, powerdown_req_in = 1'h0;
  logic boot_unlock = 1'h0, vpp_ok = 1'h1;
  logic [1:0] req_op_in = 2'h0;
  logic [ADDR_W-1:0] req_addr_in = '0, mem_addr_out;
  logic [DATA_W-1:0] req_wdata_in = '0, resp_rdata_out, mem_dq_out, mem_dq_oe_out;
  logic [DATA_W-1:0] mem_dq_in, dev_dq, dev_oe, flt = 16'h6C93;
  logic req_ready_out, resp_valid_out, chip_select_n_out, output_gate_n_out;
  logic write_strobe_n_out, width_word_out, powerdown_reset_n_out, signature_hv_pin_out;
  int error_cnt = 0, num_checks = 0;
  ////////////////////////////////////////////////////////////////
  assign mem_dq_in = (mem_dq_out & mem_dq_oe_out) | (dev_dq & dev_oe & ~mem_dq_oe_out)
    | (flt & ~dev_oe & ~mem_dq_oe_out);
  fabpc_host dut (.clk_in, .sys_rst_in, .req_valid_in, .req_op_in, .req_addr_in,
    .req_wdata_in, .req_byte_in, .req_program_in, .powerdown_req_in, .mem_dq_in,
    .req_ready_out, .resp_valid_out, .resp_rdata_out, .mem_addr_out, .mem_dq_out,
    .mem_dq_oe_out, .chip_select_n_out, .output_gate_n_out, .write_strobe_n_out,
    .width_word_out, .powerdown_reset_n_out, .signature_hv_pin_out);
  fabpc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash (.addr_in(mem_addr_out),
    .dq_in(mem_dq_in), .cs_n_in(chip_select_n_out), .oe_n_in(output_gate_n_out),
    .we_n_in(write_strobe_n_out), .word_in(width_word_out),
    .pd_n_in(powerdown_reset_n_out), .sig_hv_in(signature_hv_pin_out), .dq_out(dev_dq),
    .boot_unlock_in(boot_unlock), .vpp_ok_in(vpp_ok),
    .dq_oe_out(dev_oe));
  initial
  begin
    forever #10 clk_in = ~clk_in;
  end
  // released lanes must not look like held data
  always @(posedge clk_in)
    flt <= ~flt;
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_hi(input bit rsp);
    int n;
    logic s;
    n = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      n++;
      s = rsp ? resp_valid_out : req_ready_out;
    end
    while (s !== 1'h1 && n < 300);
    check({15'h0, s}, 16'h1);
  endtask
  task automatic xfer(input logic [1:0] op, input logic [17:0] a, input logic [15:0] d,
    input logic b, input logic p);
    wait_hi(1'h0);
    {req_valid_in, req_op_in, req_addr_in, req_wdata_in, req_byte_in, req_program_in}
      = {1'h1, op, a, d, b, p};
    @(posedge clk_in);
    #1;
    req_valid_in = 1'h0;
    wait_hi(1'h1);
  endtask
  task automatic t_word;
    xfer(OP_WRITE, 18'h00123, 16'hC3A5, 1'h0, 1'h1);
    repeat (25) @(posedge clk_in);
    xfer(OP_READ, 18'h00123, 16'h0000, 1'h0, 1'h0);
    check(resp_rdata_out, 16'hC3A5);
    $display("test word done");
  endtask
  task automatic t_byte;
    xfer(OP_WRITE, 18'h00045, 16'h005A, 1'h1, 1'h1);
    repeat (25) @(posedge clk_in);
    xfer(OP_READ, 18'h00045, 16'h0000, 1'h1, 1'h0);
    check({8'h00, resp_rdata_out[7:0]}, 16'h005A);
    $display("test byte done");
  endtask
  task automatic t_ident;
    logic [15:0] e, m;
    for (int i = 0; i < 4; i++)
    begin
      xfer(OP_IDENT, {17'h0, i[0]}, 16'h0000, i[1], 1'h0);
      e = i[0] ? PART : MAKER;
      m = i[1] ? 16'h00FF : 16'hFFFF;
      check(resp_rdata_out & m, e & m);
    end
    $display("test identifier done");
  endtask
  task automatic t_lock;
    xfer(OP_WRITE, 18'h3E010, 16'h1111, 1'h0, 1'h1);
    vpp_ok = 1'h0;
    xfer(OP_WRITE, 18'h00300, 16'h2222, 1'h0, 1'h1);
    vpp_ok = 1'h1;
    boot_unlock = 1'h1;
    xfer(OP_WRITE, 18'h3E020, 16'h5555, 1'h0, 1'h1);
    repeat (25) @(posedge clk_in);
    boot_unlock = 1'h0;
    xfer(OP_READ, 18'h3E010, 16'h0000, 1'h0, 1'h0);
    check(resp_rdata_out, 16'hFFFF);
    xfer(OP_READ, 18'h00300, 16'h0000, 1'h0, 1'h0);
    check(resp_rdata_out, 16'hFFFF);
    xfer(OP_READ, 18'h3E020, 16'h0000, 1'h0, 1'h0);
    check(resp_rdata_out, 16'h5555);
    $display("test lock done");
  endtask
  task automatic t_pd;
    xfer(OP_WRITE, 18'h00200, 16'h1234, 1'h0, 1'h1);
    powerdown_req_in = 1'h1;
    repeat (4) @(posedge clk_in);
    #1;
    check({15'h0, powerdown_reset_n_out}, 16'h0);
    check(mem_dq_oe_out, 16'h0);
    powerdown_req_in = 1'h0;
    xfer(OP_READ, 18'h00200, 16'h0000, 1'h0, 1'h0);
    check(resp_rdata_out, 16'hFFFF);
    $display("test powerdown done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_in);
    #1;
    sys_rst_in = 1'h0;
    t_word();
    t_byte();
    t_ident();
    t_lock();
    t_pd();
    summarize();
  end
  // over twenty times the expected run
  initial
  begin
    #200000;
    error_cnt++;
    summarize();
  end
endmodule
